// ===== aodc_top.v
// Purpose: Data memory, host word port, range decode and per-point output codes.
// Assumes: Host port signals are synchronous to i_clk_sys; switch pins are not.
// Notes: Codes update one clock after the memory word changes.
`timescale 1ns/1ps
`include "aodc_defs.vh"
module aodc_top #(
  parameter NPTS = `AODC_NPTS,
  parameter DEPTH = `AODC_MEM_DEPTH,
  parameter AW = 6
) (
  input wire i_clk_sys,
  input wire i_nrst,
  input wire i_wr_en,
  input wire [AW-1:0] i_wr_addr,
  input wire [15:0] i_wr_data,
  input wire [6:0] i_wr_len,
  input wire i_rd_en,
  input wire i_rd_first,
  input wire [3*NPTS-1:0] i_range_pins,
  input wire [4*NPTS-1:0] i_vsel_pins,
  output reg [15:0] o_rd_data,
  output reg o_rd_valid,
  output reg [12*NPTS-1:0] o_dac_code,
  output reg [3*NPTS-1:0] o_range_sel,
  output reg [NPTS-1:0] o_is_current,
  output reg [NPTS-1:0] o_range_fault,
  output reg [NPTS-1:0] o_vsel_fault,
  output reg [NPTS-1:0] o_data_fault
);
  reg [15:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] rd_ptr_q;
  reg [AW-1:0] rd_addr_q;
  reg [3*NPTS-1:0] rng_s1_q;
  reg [3*NPTS-1:0] rng_s2_q;
  reg [4*NPTS-1:0] vs_s1_q;
  reg [4*NPTS-1:0] vs_s2_q;
  reg [AW-1:0] rd_sel;
  reg [7:0] ptr_bin;
  reg ptr_ok;
  reg wr_ok;
  reg [15:0] wr_val;
  wire [15:0] cfg_w;
  wire [15:0] sen_w;
  wire [NPTS-1:0] fmt_bin;
  wire [NPTS-1:0] lim_on;
  wire ptr_hit;
  wire sen_hit;
  integer k;

  assign cfg_w = mem_q[`AODC_WD_CFG];
  assign sen_w = mem_q[`AODC_WD_SCALE_EN];
  // Word 14: low byte enables limits, high byte picks binary format
  assign fmt_bin = cfg_w[`AODC_CFG_FMT_LSB +: NPTS];
  assign lim_on = cfg_w[NPTS-1:0];
  assign ptr_hit = (i_wr_addr == `AODC_WD_RDPTR);
  assign sen_hit = (i_wr_addr == `AODC_WD_SCALE_EN);

  // Pointer value arrives in decimal; reject bad digits or values past the top
  always @* begin
    ptr_bin = {4'h0, i_wr_data[7:4]} * 8'd10 + {4'h0, i_wr_data[3:0]};
    ptr_ok = (i_wr_data[15:8] == 8'h00) && (i_wr_data[7:4] <= 4'h9) &&
             (i_wr_data[3:0] <= 4'h9) && (ptr_bin <= `AODC_RDPTR_MAX);
  end

  always @* begin
    wr_ok = i_wr_en;
    wr_val = i_wr_data;
    if (ptr_hit) begin
      // A longer block write would run the pointer into the next words
      wr_ok = i_wr_en && ptr_ok && (i_wr_len == 7'h01);
    end else if (sen_hit) begin
      wr_val = {8'h00, i_wr_data[7:0]};
    end
  end

  // Data memory, cleared at reset
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem_q[k] <= `AODC_RST_WORD;
      end
    end else if (wr_ok) begin
      mem_q[i_wr_addr] <= wr_val;
    end
  end

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_ptr_q <= {AW{1'b0}};
    end else if (wr_ok && ptr_hit) begin
      rd_ptr_q <= ptr_bin[AW-1:0];
    end
  end

  // Block read: first word at the pointer, later words follow in order
  always @* begin
    rd_sel = i_rd_first ? rd_ptr_q : rd_addr_q;
  end

  // Next address of a running block read; wraps at the top of memory
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_addr_q <= {AW{1'b0}};
    end else if (i_rd_en) begin
      rd_addr_q <= rd_sel + {{(AW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd_data <= 16'h0000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= mem_q[rd_sel];
      end
    end
  end

  // Switch pins are asynchronous to the unit clock
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rng_s1_q <= {3*NPTS{1'b0}};
      rng_s2_q <= {3*NPTS{1'b0}};
    end else begin
      rng_s1_q <= i_range_pins;
      rng_s2_q <= rng_s1_q;
    end
  end

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      vs_s1_q <= {4*NPTS{1'b0}};
      vs_s2_q <= {4*NPTS{1'b0}};
    end else begin
      vs_s1_q <= i_vsel_pins;
      vs_s2_q <= vs_s1_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPTS; g = g + 1) begin : g_pt
      wire [2:0] rc;
      wire [3:0] vs;
      reg [3:0] vs_exp;
      reg rc_bad;
      reg cur;
      reg bip;
      wire is_bin;
      wire sc_en;
      wire lim_en;
      wire signed [17:0] val;
      wire signed [17:0] slo;
      wire signed [17:0] shi;
      wire signed [17:0] llo;
      wire signed [17:0] lhi;
      wire bad_val;
      wire bad_slo;
      wire bad_shi;
      wire bad_llo;
      wire bad_lhi;
      reg in_range;
      wire [11:0] code;
      wire [15:0] pt_w;
      wire [15:0] slo_w;
      wire [15:0] shi_w;
      wire [15:0] llo_w;
      wire [15:0] lhi_w;
      wire vs_bad;
      reg word_ok;

      assign rc = rng_s2_q[3*g +: 3];
      assign vs = vs_s2_q[4*g +: 4];
      assign is_bin = fmt_bin[g];
      assign sc_en = sen_w[g];
      assign lim_en = lim_on[g];
      assign vs_bad = (vs != vs_exp);
      // Scaling words sit in pairs from word 15, limit words in pairs from word 31
      assign pt_w = mem_q[`AODC_WD_PT_BASE + g];
      assign slo_w = mem_q[`AODC_WD_SCL_BASE + 2*g];
      assign shi_w = mem_q[`AODC_WD_SCL_BASE + 2*g + 1];
      assign llo_w = mem_q[`AODC_WD_LIM_BASE + 2*g];
      assign lhi_w = mem_q[`AODC_WD_LIM_BASE + 2*g + 1];

      always @* begin
        vs_exp = 4'h0;
        rc_bad = 1'b0;
        cur = 1'b0;
        bip = 1'b0;
        case (rc)
          `AODC_RC_0_10V: vs_exp = `AODC_VS_0_10V;
          `AODC_RC_0_5V: vs_exp = `AODC_VS_0_5V;
          `AODC_RC_PM5V: begin
            vs_exp = `AODC_VS_PM5V;
            bip = 1'b1;
          end
          `AODC_RC_PM10V: begin
            vs_exp = `AODC_VS_PM10V;
            bip = 1'b1;
          end
          `AODC_RC_0_20MA: cur = 1'b1;
          `AODC_RC_4_20MA: cur = 1'b1;
          default: rc_bad = 1'b1;
        endcase
      end

      aodc_word_decode u_dec_val (
        .i_word(pt_w),
        .i_is_bin(is_bin),
        .o_value(val),
        .o_bad(bad_val)
      );
      aodc_word_decode u_dec_slo (
        .i_word(slo_w),
        .i_is_bin(is_bin),
        .o_value(slo),
        .o_bad(bad_slo)
      );
      aodc_word_decode u_dec_shi (
        .i_word(shi_w),
        .i_is_bin(is_bin),
        .o_value(shi),
        .o_bad(bad_shi)
      );
      aodc_word_decode u_dec_llo (
        .i_word(llo_w),
        .i_is_bin(is_bin),
        .o_value(llo),
        .o_bad(bad_llo)
      );
      aodc_word_decode u_dec_lhi (
        .i_word(lhi_w),
        .i_is_bin(is_bin),
        .o_value(lhi),
        .o_bad(bad_lhi)
      );

      always @* begin
        if (sc_en && is_bin) begin
          in_range = (val >= -`AODC_SC_BIN_LIM) && (val <= `AODC_SC_BIN_LIM);
        end else if (sc_en) begin
          in_range = (val >= -`AODC_SC_BCD_LIM) && (val <= `AODC_SC_BCD_LIM);
        end else if (is_bin) begin
          in_range = (val >= `AODC_NOSC_MIN) && (val <= `AODC_CODE_MAX);
        end else begin
          in_range = (val >= `AODC_NOSC_MIN) && (val <= `AODC_NOSC_BCD_MAX);
        end
      end

      // One flag gates both the fault output and the converter update
      always @* begin
        word_ok = ~bad_val & in_range;
        if (sc_en && (bad_slo || bad_shi)) begin
          word_ok = 1'b0;
        end
        if (lim_en && (bad_llo || bad_lhi)) begin
          word_ok = 1'b0;
        end
      end

      aodc_scale u_scale (
        .i_value(val),
        .i_scl_lo(slo),
        .i_scl_hi(shi),
        .i_lim_lo(llo),
        .i_lim_hi(lhi),
        .i_scale_en(sc_en),
        .i_lim_en(lim_en),
        .i_bipolar(bip),
        .o_code(code)
      );

      always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          o_range_sel[3*g +: 3] <= 3'h0;
          o_is_current[g] <= 1'b0;
          o_range_fault[g] <= 1'b0;
          o_vsel_fault[g] <= 1'b0;
        end else begin
          o_range_sel[3*g +: 3] <= rc;
          o_is_current[g] <= cur;
          o_range_fault[g] <= rc_bad;
          // Current ranges never look at the voltage pins
          o_vsel_fault[g] <= ~cur & ~rc_bad & vs_bad;
        end
      end

      always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          o_dac_code[12*g +: 12] <= 12'h000;
          o_data_fault[g] <= 1'b0;
        end else begin
          o_data_fault[g] <= ~word_ok;
          // A rejected word leaves the last good code on the converter
          if (word_ok) begin
            o_dac_code[12*g +: 12] <= code;
          end
        end
      end
    end
  endgenerate
endmodule

// ===== aodc_defs.vh
// Purpose: Shared constants for the analog output data control block.
// Assumes: Word-addressed data memory, one 16-bit word per address.
// Notes: Word addresses are plain indices into the unit's data memory.
`ifndef AODC_DEFS_VH
`define AODC_DEFS_VH

`define AODC_NPTS 8
`define AODC_MEM_DEPTH 64
`define AODC_WD_PT_BASE 1
`define AODC_WD_RDPTR 12
`define AODC_WD_SCALE_EN 13
`define AODC_WD_CFG 14
`define AODC_WD_SCL_BASE 15
`define AODC_WD_LIM_BASE 31
`define AODC_RDPTR_MAX 61
`define AODC_CFG_FMT_LSB 8
`define AODC_RST_WORD 16'h0000
`define AODC_CODE_MAX 4095
`define AODC_BIP_OFFSET 2048
`define AODC_NOSC_MIN (-2048)
`define AODC_NOSC_BCD_MAX 4095
`define AODC_SC_BCD_LIM 7999
`define AODC_SC_BIN_LIM 32767

// Range codes from the three pins {pin1,pin2,pin3}
`define AODC_RC_0_10V 3'h6
`define AODC_RC_0_5V 3'h7
`define AODC_RC_PM5V 3'h5
`define AODC_RC_PM10V 3'h4
`define AODC_RC_0_20MA 3'h2
`define AODC_RC_4_20MA 3'h3

// Voltage-range pin positions {pin4,pin3,pin2,pin1}
`define AODC_VS_PM10V 4'h8
`define AODC_VS_PM5V 4'h4
`define AODC_VS_0_10V 4'h2
`define AODC_VS_0_5V 4'h1

`endif

// ===== aodc_word_decode.v
// Purpose: Turn one data word into a signed value in decimal or binary format.
// Assumes: Decimal words carry the sign in bit 15, thousands digit in bits 14:12.
// Notes: Pure combinational; invalid decimal digits raise o_bad.
`timescale 1ns/1ps
module aodc_word_decode (
  input wire [15:0] i_word,
  input wire i_is_bin,
  output wire signed [17:0] o_value,
  output wire o_bad
);
  wire [3:0] th;
  wire [3:0] hu;
  wire [3:0] te;
  wire [3:0] un;
  wire [17:0] mag;
  wire signed [17:0] bcd_val;
  wire signed [17:0] bin_val;
  wire digit_bad;

  assign th = {1'b0, i_word[14:12]};
  assign hu = i_word[11:8];
  assign te = i_word[7:4];
  assign un = i_word[3:0];
  assign digit_bad = (hu > 4'h9) | (te > 4'h9) | (un > 4'h9);
  assign mag = {14'h0, th} * 18'd1000 + {14'h0, hu} * 18'd100 + {14'h0, te} * 18'd10 +
               {14'h0, un};
  assign bcd_val = i_word[15] ? -$signed(mag) : $signed(mag);
  assign bin_val = {{2{i_word[15]}}, i_word};
  assign o_value = i_is_bin ? bin_val : bcd_val;
  assign o_bad = ~i_is_bin & digit_bad;
endmodule

// ===== aodc_scale.v
// Purpose: Clamp, scale and offset one point's value into a 12-bit converter code.
// Assumes: All values already decoded to signed form in the point's format.
// Notes: The divider is combinational; it is wide but keeps the path simple.
`timescale 1ns/1ps
`include "aodc_defs.vh"
module aodc_scale (
  input wire signed [17:0] i_value,
  input wire signed [17:0] i_scl_lo,
  input wire signed [17:0] i_scl_hi,
  input wire signed [17:0] i_lim_lo,
  input wire signed [17:0] i_lim_hi,
  input wire i_scale_en,
  input wire i_lim_en,
  input wire i_bipolar,
  output reg [11:0] o_code
);
  reg signed [17:0] v;
  reg signed [18:0] span;
  reg signed [18:0] num;
  reg signed [18:0] t;
  reg [31:0] prod;
  localparam signed [18:0] BIP_OFS = `AODC_BIP_OFFSET;
  always @* begin
    v = i_value;
    span = 19'sd0;
    num = 19'sd0;
    t = 19'sd0;
    prod = 32'h0;
    o_code = 12'h000;
    if (i_lim_en) begin
      if (i_value > i_lim_hi) begin
        v = i_lim_hi;
      end else if (i_value < i_lim_lo) begin
        v = i_lim_lo;
      end
    end
    if (i_scale_en) begin
      span = {i_scl_hi[17], i_scl_hi} - {i_scl_lo[17], i_scl_lo};
      num = {v[17], v} - {i_scl_lo[17], i_scl_lo};
      if (span <= 19'sd0 || num <= 19'sd0) begin
        o_code = 12'h000;
      end else if (num >= span) begin
        o_code = 12'hFFF;
      end else begin
        prod = ({13'h0, num[18:0]} * `AODC_CODE_MAX) / {13'h0, span[18:0]};
        o_code = prod[11:0];
      end
    end else begin
      t = i_bipolar ? ({v[17], v} + BIP_OFS) : {v[17], v};
      if (t < 19'sd0) begin
        o_code = 12'h000;
      end else if (t > `AODC_CODE_MAX) begin
        o_code = 12'hFFF;
      end else begin
        o_code = t[11:0];
      end
    end
  end
endmodule

// ===== aodc_top_props.sv
// Purpose: Port-level checks for aodc_top.
// Assumes: Switch pins change on clock edges in simulation.
// Notes: Pin latency checks wait three edges after reset, two sync stages plus the output register.
`timescale 1ns/1ps
module aodc_props #(
  parameter NPTS = 8,
  parameter AW = 6
) (
  input wire i_clk_sys,
  input wire i_nrst,
  input wire i_rd_en,
  input wire [3*NPTS-1:0] i_range_pins,
  input wire [4*NPTS-1:0] i_vsel_pins,
  input wire [15:0] o_rd_data,
  input wire o_rd_valid,
  input wire [12*NPTS-1:0] o_dac_code,
  input wire [3*NPTS-1:0] o_range_sel,
  input wire [NPTS-1:0] o_is_current,
  input wire [NPTS-1:0] o_range_fault,
  input wire [NPTS-1:0] o_vsel_fault
);
  reg [1:0] cnt_q;
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) cnt_q <= 2'h0;
    else if (cnt_q != 2'h3) cnt_q <= cnt_q + 2'h1;
  end
  function automatic [3:0] onehot(input [2:0] rc);
    case (rc)
      3'h6: onehot = 4'h2;
      3'h7: onehot = 4'h1;
      3'h5: onehot = 4'h4;
      default: onehot = 4'h8;
    endcase
  endfunction
  default clocking dc @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  a_rd_valid_one: assert property (i_rd_en |=> o_rd_valid)
    else $error("read not answered");
  a_rd_valid_none: assert property (!i_rd_en |=> !o_rd_valid)
    else $error("read valid without request");
  a_rd_data_hold: assert property (!o_rd_valid |-> $stable(o_rd_data))
    else $error("read data moved without read");
  a_rst_zero: assert property (cnt_q == 2'h0 |-> o_dac_code == 0 && !o_rd_valid)
    else $error("outputs not clear after reset");
  a_range_lat: assert property (cnt_q == 2'h3 |-> o_range_sel == $past(i_range_pins, 3))
    else $error("range code latency wrong");
  a_cur_flag: assert property (o_is_current[0] == (o_range_sel[2:1] == 2'h1))
    else $error("current flag wrong");
  a_rng_fault: assert property (cnt_q != 2'h0 |->
    o_range_fault[0] == (o_range_sel[2:1] == 2'h0))
    else $error("range fault wrong");
  a_cur_no_vsel: assert property (o_is_current[0] |-> !o_vsel_fault[0])
    else $error("voltage pins judged in current range");
  a_vsel_match: assert property (cnt_q == 2'h3 && o_range_sel[2] |->
    o_vsel_fault[0] == ($past(i_vsel_pins[3:0], 3) != onehot(o_range_sel[2:0])))
    else $error("voltage pin check wrong");
endmodule
bind aodc_top aodc_props #(.NPTS(NPTS), .AW(AW)) props_u (.i_clk_sys(i_clk_sys),
  .i_nrst(i_nrst), .i_rd_en(i_rd_en), .i_range_pins(i_range_pins), .i_vsel_pins(i_vsel_pins),
  .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_dac_code(o_dac_code),
  .o_range_sel(o_range_sel), .o_is_current(o_is_current), .o_range_fault(o_range_fault),
  .o_vsel_fault(o_vsel_fault));

// ===== aodc_host_model.sv
// Purpose: Host processor doing word-by-word block transfers.
// Assumes: One word per call; the caller sets the block length.
// Notes: Write data is inverted once released so stale values never look valid.
`timescale 1ns/1ps
module aodc_host_model (
  input wire i_clk_sys,
  input wire i_rd_valid,
  input wire [15:0] i_rd_data,
  output reg o_wr_en,
  output reg [5:0] o_wr_addr,
  output reg [15:0] o_wr_data,
  output reg [6:0] o_wr_len,
  output reg o_rd_en,
  output reg o_rd_first
);
  initial begin
    o_wr_en = 1'b0;
    o_wr_addr = 6'h00;
    o_wr_data = 16'h0000;
    o_wr_len = 7'h01;
    o_rd_en = 1'b0;
    o_rd_first = 1'b0;
  end
  task automatic wr(input [5:0] a, input [15:0] d, input [6:0] n);
    @(posedge i_clk_sys);
    o_wr_en <= 1'b1;
    o_wr_addr <= a;
    o_wr_data <= d;
    o_wr_len <= n;
    @(posedge i_clk_sys);
    o_wr_en <= 1'b0;
    o_wr_data <= ~d;
  endtask
  task automatic rd(input f, output [15:0] d, output ok);
    ok = 1'b0;
    d = 16'h0000;
    @(posedge i_clk_sys);
    o_rd_en <= 1'b1;
    o_rd_first <= f;
    @(posedge i_clk_sys);
    o_rd_en <= 1'b0;
    repeat (4) begin
      @(posedge i_clk_sys);
      if (!ok && i_rd_valid === 1'b1) begin
        ok = 1'b1;
        d = i_rd_data;
      end
    end
  endtask
endmodule

// ===== aodc_top_tb.sv
// Purpose: Self-checking bench for aodc_top.
// Assumes: Point 1 carries the code tests; other points stay at 0 to 10 V.
// Notes: Waits of three edges follow the one-clock code update plus launch.
`timescale 1ns/1ps
module aodc_top_tb;
  reg i_clk_sys = 1'b0;
  reg i_nrst = 1'b0;
  reg [23:0] rng = 24'hDB6DB6;
  reg [31:0] vsel = 32'h22222222;
  wire wr_en, rd_en, rd_first, rd_valid;
  wire [5:0] wr_addr;
  wire [15:0] wr_data, rd_data;
  wire [6:0] wr_len;
  wire [95:0] code;
  wire [23:0] rsel;
  wire [7:0] cur, rfault, vfault, dfault;
  integer mismatches = 0;
  integer comparisons = 0;
  integer i;
  reg [15:0] d;
  reg ok;
  always #2.5 i_clk_sys = ~i_clk_sys;
  aodc_host_model host_u (.i_clk_sys(i_clk_sys), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_wr_len(wr_len),
    .o_rd_en(rd_en), .o_rd_first(rd_first));
  aodc_top dut_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_wr_en(wr_en),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_wr_len(wr_len), .i_rd_en(rd_en),
    .i_rd_first(rd_first), .i_range_pins(rng), .i_vsel_pins(vsel), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_dac_code(code), .o_range_sel(rsel), .o_is_current(cur),
    .o_range_fault(rfault), .o_vsel_fault(vfault), .o_data_fault(dfault));
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string name, input [15:0] seen, input [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task setpt(input [2:0] r, input [3:0] v);
    @(posedge i_clk_sys);
    rng[2:0] <= r;
    vsel[3:0] <= v;
    repeat (4) @(posedge i_clk_sys);
  endtask
  // Write point 1 and give the code its one-clock update before looking
  task wcode(input [15:0] w, input [15:0] exp);
    host_u.wr(6'h01, w, 7'h01);
    repeat (3) @(posedge i_clk_sys);
    chk("code", {4'h0, code[11:0]}, exp);
  endtask
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    for (i = 1; i <= 8; i = i + 1) host_u.wr(i, 16'h0100 + i, 7'h01);
    host_u.wr(6'h0D, 16'hFF80, 7'h01);
    // Pointer loads of wrong length or beyond 61 must be dropped
    host_u.wr(6'h0C, 16'h0001, 7'h01);
    host_u.wr(6'h0C, 16'h0005, 7'h02);
    host_u.wr(6'h0C, 16'h0062, 7'h01);
    for (i = 1; i <= 13; i = i + 1) begin
      host_u.rd(i == 1, d, ok);
      if (!ok) begin
        mismatches = mismatches + 1;
        results;
      end
      chk("rdword", d, i <= 8 ? 16'h0100 + i : i == 12 ? 16'h0001 : i == 13 ? 16'h0080 : 0);
    end
    $display("test registers done");
    host_u.wr(6'h0D, 16'h0000, 7'h01);
    host_u.wr(6'h0E, 16'h0000, 7'h01);
    wcode(16'h1234, 16'h04D2);
    host_u.wr(6'h0E, 16'h0100, 7'h01);
    wcode(16'h0FFF, 16'h0FFF);
    setpt(3'h4, 4'h8);
    wcode(16'hF800, 16'h0000);
    chk("vfault", {15'h0, vfault[0]}, 16'h0000);
    setpt(3'h6, 4'h2);
    wcode(16'h0123, 16'h0123);
    wcode(16'h1000, 16'h0123);
    chk("dfault", {15'h0, dfault[0]}, 16'h0001);
    $display("test formats done");
    host_u.wr(6'h1F, 16'h0010, 7'h01);
    host_u.wr(6'h20, 16'h0100, 7'h01);
    host_u.wr(6'h0E, 16'h0101, 7'h01);
    wcode(16'h0200, 16'h0100);
    wcode(16'h0001, 16'h0010);
    host_u.wr(6'h0E, 16'h0100, 7'h01);
    host_u.wr(6'h0F, 16'h0000, 7'h01);
    host_u.wr(6'h10, 16'h2000, 7'h01);
    host_u.wr(6'h0D, 16'h0001, 7'h01);
    wcode(16'h1000, 16'h07FF);
    wcode(16'hF000, 16'h0000);
    wcode(16'h7FFF, 16'h0FFF);
    wcode(16'h8000, 16'h0FFF);
    chk("dfault", {15'h0, dfault[0]}, 16'h0001);
    $display("test limits and scaling done");
    setpt(3'h2, 4'h1);
    chk("cur", {15'h0, cur[0]}, 16'h0001);
    chk("vfault", {15'h0, vfault[0]}, 16'h0000);
    setpt(3'h0, 4'h2);
    chk("rfault", {15'h0, rfault[0]}, 16'h0001);
    $display("test ranges done");
    results;
  end
endmodule
